// File: hdl/strap_pkg.sv
package strap_pkg;

    // strap pin bus width (lines 0..40)
    localparam int STRAP_W = 41;

    // documented i/o ports
    localparam logic [15:0] INDEX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;

    // register indexes
    localparam logic [7:0] IDX_CAPTURE_0 = 8'h4a;
    localparam logic [7:0] IDX_CAPTURE_1 = 8'h4b;
    localparam logic [7:0] IDX_CLK_PAD = 8'h4c;
    localparam logic [7:0] IDX_HCLK_SPEED = 8'h5f;

    // strap line numbers
    localparam int LN_HCLK_SPD0 = 2;
    localparam int LN_HCLK_SPD1 = 3;
    localparam int LN_PCI_DIV1 = 4;
    localparam int LN_MCLK_SYNC = 5;
    localparam int LN_PCI_PLL0 = 6;
    localparam int LN_PCI_PLL1 = 7;
    localparam int LN_BUS_MODE0 = 8;
    localparam int LN_BUS_MODE1 = 9;
    localparam int LN_RSV_VIS0 = 10;
    localparam int LN_CPU_MULT0 = 14;
    localparam int LN_PCI_DIV0 = 17;
    localparam int LN_HCLK_PAD = 18;
    localparam int LN_MCLK_PAD = 19;
    localparam int LN_DOT_PAD = 20;
    localparam int LN_RSV_5F0 = 21;
    localparam int LN_RSV_5F2 = 23;
    localparam int LN_HCLK_PLL0 = 24;
    localparam int LN_BOOT_WIDTH = 36;
    localparam int LN_CPU_MULT1 = 40;

    // bus mode encodings
    localparam logic [1:0] BUS_ISA = 2'h0;
    localparam logic [1:0] BUS_PCMCIA = 2'h1;
    localparam logic [1:0] BUS_LOCAL = 2'h2;

    // software-writable masks of the mixed registers
    localparam logic [7:0] CLK_PAD_WR_MASK = 8'hc3;
    localparam logic [7:0] HCLK_SPEED_WR_MASK = 8'h02;
    localparam logic [7:0] SOFT_RESET_VAL = 8'h00;

    // sampling point after reset release
    localparam int SAMPLE_DELAY_NS = 1000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SAMPLE_CYCLES =
        (SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 6;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_DONE = 2'b10
    } sample_state_t;

    typedef struct packed {
        logic [1:0] pci_pll;
        logic [1:0] bus_mode;
        logic mclk_sync;
        logic [1:0] pci_div;
        logic [1:0] cpu_mult;
        logic [3:0] rsv_vis;
        logic boot_16;
        logic hclk_pad_out;
        logic mclk_pad_drive;
        logic dot_pad_out;
        logic [1:0] hclk_speed;
        logic [2:0] hclk_pll;
        logic [1:0] rsv_5f;
        logic [13:0] hidden;
    } strap_cfg_t;

    typedef struct packed {
        logic isa_en;
        logic pcmcia_en;
        logic local_bus_en;
    } bus_enable_t;

endpackage : strap_pkg

// File: hdl/strap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module strap_sync
    import strap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [STRAP_W-1:0] pins,
    output logic [STRAP_W-1:0] q,
    output logic stable
);

    logic [STRAP_W-1:0] s1_r;
    logic [STRAP_W-1:0] s2_r;
    logic [STRAP_W-1:0] s3_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign q = s3_r;
    assign stable = (s2_r == s3_r);

endmodule : strap_sync
`default_nettype wire

// File: hdl/boot_strap_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module boot_strap_sampler
    import strap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [STRAP_W-1:0] strap_pin_lines,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic strap_lines_released,
    output strap_cfg_t cfg,
    output bus_enable_t bus_en,
    output logic pci_pll_high_range,
    output logic pci_pll_reserved
);

    function automatic strap_cfg_t extract(
        input logic [STRAP_W-1:0] p
    );
        strap_cfg_t c;
        c = '0;
        c.pci_pll = {p[LN_PCI_PLL1], p[LN_PCI_PLL0]};
        c.bus_mode = {p[LN_BUS_MODE1], p[LN_BUS_MODE0]};
        c.mclk_sync = p[LN_MCLK_SYNC];
        c.pci_div = {p[LN_PCI_DIV1], p[LN_PCI_DIV0]};
        c.cpu_mult = {p[LN_CPU_MULT1], p[LN_CPU_MULT0]};
        c.rsv_vis = p[LN_RSV_VIS0 +: 4];
        c.boot_16 = p[LN_BOOT_WIDTH];
        c.hclk_pad_out = p[LN_HCLK_PAD];
        c.mclk_pad_drive = p[LN_MCLK_PAD];
        c.dot_pad_out = p[LN_DOT_PAD];
        c.hclk_speed = {p[LN_HCLK_SPD1], p[LN_HCLK_SPD0]};
        c.hclk_pll = p[LN_HCLK_PLL0 +: 3];
        c.rsv_5f = {p[LN_RSV_5F2], p[LN_RSV_5F0]};
        // internal-only straps, kept out of every readable register
        c.hidden = {p[38], p[37],
                    p[35:27],
                    p[16], p[15],
                    p[1]};
        return c;
    endfunction : extract

    function automatic bus_enable_t decode_bus(input logic [1:0] m);
        bus_enable_t b;
        b.isa_en = (m == BUS_ISA);
        b.pcmcia_en = (m == BUS_PCMCIA);
        b.local_bus_en = (m == BUS_LOCAL);
        return b;
    endfunction : decode_bus

    // bit 0 marks the index port, bit 1 the data port
    function automatic logic [1:0] port_hit(input logic [15:0] a);
        logic [1:0] h;
        h = 2'h0;
        if (a == INDEX_PORT) begin
            h[0] = 1'h1;
        end else if (a == DATA_PORT) begin
            h[1] = 1'h1;
        end
        return h;
    endfunction : port_hit

    logic [STRAP_W-1:0] pins_q;
    logic pins_stable;

    // capture is gated on agreement of the last two stages
    strap_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pins(strap_pin_lines),
        .q(pins_q),
        .stable(pins_stable)
    );

    // sampling sequencer
    // every capture output loads on the one capture edge
    sample_state_t state_r;
    sample_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    strap_cfg_t cfg_r;
    strap_cfg_t cfg_nxt;
    bus_enable_t bus_en_r;
    bus_enable_t bus_en_nxt;
    logic pll_hi_r;
    logic pll_hi_nxt;
    logic pll_rsv_r;
    logic pll_rsv_nxt;
    logic released_r;
    logic released_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cfg_nxt = cfg_r;
        bus_en_nxt = bus_en_r;
        pll_hi_nxt = pll_hi_r;
        pll_rsv_nxt = pll_rsv_r;
        released_nxt = released_r;
        case (state_r)
            ST_SETTLE: begin
                // pins assumed held steady through this window
                if (cnt_r == CNT_W'(SAMPLE_CYCLES - 1)) begin
                    state_nxt = ST_CAPTURE;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            ST_CAPTURE: begin
                // wait for synchroniser agreement so one capture is clean
                // straps that never settle hold the sampler here
                if (pins_stable) begin
                    cfg_nxt = extract(pins_q);
                    bus_en_nxt = decode_bus(cfg_nxt.bus_mode);
                    pll_hi_nxt = (cfg_nxt.pci_pll == 2'h1);
                    pll_rsv_nxt = cfg_nxt.pci_pll[1];
                    released_nxt = 1'b1;
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // no resample until the next reset
                state_nxt = ST_DONE;
            end
            default: begin
                // unused code falls back to settling
                state_nxt = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_SETTLE;
            cnt_r <= '0;
            cfg_r <= '0;
            bus_en_r <= '0;
            pll_hi_r <= 1'b0;
            pll_rsv_r <= 1'b0;
            released_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cfg_r <= cfg_nxt;
            bus_en_r <= bus_en_nxt;
            pll_hi_r <= pll_hi_nxt;
            pll_rsv_r <= pll_rsv_nxt;
            released_r <= released_nxt;
        end
    end

    // index/data port access
    logic [1:0] wr_hit;
    logic [1:0] rd_hit;
    logic [7:0] index_r;
    logic [7:0] index_nxt;
    logic [7:0] pad_soft_r;
    logic [7:0] pad_soft_nxt;
    logic [7:0] spd_soft_r;
    logic [7:0] spd_soft_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] img_cap0;
    logic [7:0] img_cap1;
    logic [7:0] img_pad;
    logic [7:0] img_spd;
    logic [7:0] reg_val;

    // strobes qualified once, shared by every register group
    assign wr_hit = io_wr ? port_hit(io_addr) : 2'h0;
    assign rd_hit = io_rd ? port_hit(io_addr) : 2'h0;

    // register images; unused positions read as zero, rsv_vis and rsv_5f read their sampled straps
    always_comb begin
        img_cap0 = {cfg_r.pci_pll,
                    cfg_r.bus_mode,
                    1'h0,
                    cfg_r.mclk_sync,
                    cfg_r.pci_div};
        img_cap1 = {cfg_r.cpu_mult,
                    cfg_r.rsv_vis,
                    1'h0,
                    cfg_r.boot_16};
        // soft bits overlay; strap-owned positions come from cfg only
        img_pad = (pad_soft_r & CLK_PAD_WR_MASK) |
                  {3'h0,
                   cfg_r.dot_pad_out,
                   cfg_r.mclk_pad_drive,
                   cfg_r.hclk_pad_out,
                   2'h0};
        img_spd = (spd_soft_r & HCLK_SPEED_WR_MASK) |
                  {cfg_r.hclk_speed,
                   cfg_r.hclk_pll,
                   cfg_r.rsv_5f[1],
                   1'h0,
                   cfg_r.rsv_5f[0]};
    end

    always_comb begin
        reg_val = 8'h00;
        if (index_r == IDX_CAPTURE_0) begin
            reg_val = img_cap0;
        end else if (index_r == IDX_CAPTURE_1) begin
            reg_val = img_cap1;
        end else if (index_r == IDX_CLK_PAD) begin
            reg_val = img_pad;
        end else if (index_r == IDX_HCLK_SPEED) begin
            reg_val = img_spd;
        end
    end

    always_comb begin
        index_nxt = index_r;
        if (wr_hit[0]) begin
            index_nxt = io_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            index_r <= 8'h00;
        end else begin
            index_r <= index_nxt;
        end
    end

    // strap-owned bits are masked off, so writes never alter them
    always_comb begin
        pad_soft_nxt = pad_soft_r;
        spd_soft_nxt = spd_soft_r;
        if (wr_hit[1]) begin
            if (index_r == IDX_CLK_PAD) begin
                pad_soft_nxt = io_wdata & CLK_PAD_WR_MASK;
            end else if (index_r == IDX_HCLK_SPEED) begin
                spd_soft_nxt = io_wdata & HCLK_SPEED_WR_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_soft_r <= SOFT_RESET_VAL;
            spd_soft_r <= SOFT_RESET_VAL;
        end else begin
            pad_soft_r <= pad_soft_nxt;
            spd_soft_r <= spd_soft_nxt;
        end
    end

    // read data holds until the next read strobe
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_hit[0]) begin
            rdata_nxt = index_r;
        end else if (rd_hit[1]) begin
            rdata_nxt = reg_val;
        end else if (io_rd) begin
            rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign io_rdata = rdata_r;
    assign strap_lines_released = released_r;
    assign cfg = cfg_r;
    assign bus_en = bus_en_r;
    assign pci_pll_high_range = pll_hi_r;
    assign pci_pll_reserved = pll_rsv_r;

endmodule : boot_strap_sampler
`default_nettype wire

// File: verif/strap_board.sv
`timescale 1ns/1ps
`default_nettype none
module strap_board
    import strap_pkg::*;
#(
    parameter logic [STRAP_W-1:0] RSV_UP = '0,
    parameter logic [STRAP_W-1:0] RSV_MSK = '0
) (
    input wire logic clk,
    input wire logic released,
    input wire logic [STRAP_W-1:0] user,
    output logic [STRAP_W-1:0] lines
);
    logic [STRAP_W-1:0] board;
    logic [STRAP_W-1:0] bus_r;
    assign board = (user & ~RSV_MSK) | RSV_UP;
    // memory traffic after release flips every cycle
    always_ff @(posedge clk) begin
        bus_r <= released ? ~bus_r : ~board;
    end
    assign lines = released ? bus_r : board;
endmodule : strap_board
`default_nettype wire

// File: verif/boot_strap_sampler_checker.sv
`timescale 1ns/1ps
`default_nettype none
module boot_strap_sampler_checker
    import strap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic strap_lines_released,
    input wire strap_cfg_t cfg,
    input wire bus_enable_t bus_en,
    input wire logic pci_pll_high_range,
    input wire logic pci_pll_reserved
);
    logic [7:0] idx_r;
    logic [7:0] idx_nxt;
    logic [7:0] cap0;
    logic rel;
    assign rel = strap_lines_released;
    assign cap0 = {cfg.pci_pll, cfg.bus_mode, 1'b0, cfg.mclk_sync,
                   cfg.pci_div};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_comb begin
        idx_nxt = idx_r;
        if (!rst_n)
            idx_nxt = 8'h00;
        else if (io_wr && io_addr == INDEX_PORT)
            idx_nxt = io_wdata;
    end
    always_ff @(posedge clk) begin
        idx_r <= idx_nxt;
    end
    property p_rel_hold;
        rel |=> rel;
    endproperty
    a_rel_hold: assert property (p_rel_hold)
        else $error("released fell");
    property p_cfg_hold;
        rel |=> $stable(cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("cfg changed after capture");
    property p_isa;
        rel |-> bus_en.isa_en == (cfg.bus_mode == BUS_ISA);
    endproperty
    a_isa: assert property (p_isa)
        else $error("isa enable wrong");
    property p_pcm;
        rel |-> bus_en.pcmcia_en == (cfg.bus_mode == BUS_PCMCIA);
    endproperty
    a_pcm: assert property (p_pcm)
        else $error("pcmcia enable wrong");
    property p_loc;
        rel |-> bus_en.local_bus_en == (cfg.bus_mode == BUS_LOCAL);
    endproperty
    a_loc: assert property (p_loc)
        else $error("local bus enable wrong");
    property p_pll_hi;
        rel |-> pci_pll_high_range == (cfg.pci_pll == 2'h1);
    endproperty
    a_pll_hi: assert property (p_pll_hi)
        else $error("pll range flag wrong");
    property p_pll_rsv;
        rel |-> pci_pll_reserved == cfg.pci_pll[1];
    endproperty
    a_pll_rsv: assert property (p_pll_rsv)
        else $error("pll reserved flag wrong");
    property p_rd_4a;
        io_rd && io_addr == DATA_PORT && idx_r == IDX_CAPTURE_0
            |=> io_rdata == $past(cap0);
    endproperty
    a_rd_4a: assert property (p_rd_4a)
        else $error("capture 0 read wrong");
    property p_unmap;
        io_rd && io_addr != INDEX_PORT && io_addr != DATA_PORT
            |=> io_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
endmodule : boot_strap_sampler_checker
bind boot_strap_sampler boot_strap_sampler_checker i_chk (
    .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .strap_lines_released(strap_lines_released), .cfg(cfg),
    .bus_en(bus_en), .pci_pll_high_range(pci_pll_high_range),
    .pci_pll_reserved(pci_pll_reserved)
);
`default_nettype wire

// File: verif/boot_strap_sampler_test.sv
`timescale 1ns/1ps
`default_nettype none
module boot_strap_sampler_test
    import strap_pkg::*;
;
    localparam logic [STRAP_W-1:0] RSV_UP = 41'h0f_f8a1_b002;
    localparam logic [STRAP_W-1:0] RSV_MSK = 41'h6f_f8a1_bc02;
    typedef struct packed {
        logic [STRAP_W-1:0] pins;
        bus_enable_t en;
        logic [1:0] fl;
    } row_t;
    localparam row_t ROWS [4] = '{'{41'h0, 3'b100, 2'b00},
        '{41'h1ff_ffff_ffff, 3'b000, 2'b01},
        '{41'h155_5555_5555, 3'b010, 2'b10},
        '{41'h0aa_aaaa_aaaa, 3'b001, 2'b01}};
    localparam logic [7:0] IDXS [4] = '{IDX_CAPTURE_0, IDX_CAPTURE_1,
        IDX_CLK_PAD, IDX_HCLK_SPEED};
    localparam logic [7:0] WMSK [4] = '{8'h00, 8'h00, CLK_PAD_WR_MASK,
        HCLK_SPEED_WR_MASK};
    logic clk;
    logic rst_n;
    logic io_wr;
    logic io_rd;
    logic rel;
    logic hi;
    logic rsv;
    logic [15:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic [7:0] v;
    logic [STRAP_W-1:0] user;
    logic [STRAP_W-1:0] lines;
    bus_enable_t bus_en;
    strap_cfg_t cfg;
    logic [13:0] hx;
    logic [7:0] ev;
    int err_total = 0;
    int num_checks = 0;
    strap_board #(.RSV_UP(RSV_UP), .RSV_MSK(RSV_MSK)) i_strap_board (
        .clk(clk), .released(rel), .user(user), .lines(lines));
    boot_strap_sampler i_boot_strap_sampler (.clk(clk), .rst_n(rst_n),
        .strap_pin_lines(lines), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .strap_lines_released(rel), .cfg(cfg), .bus_en(bus_en),
        .pci_pll_high_range(hi), .pci_pll_reserved(rsv));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [15:0] a, logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        // idle edge keeps strobes of back-to-back calls apart
        @(negedge clk);
    endtask : wr
    // data is registered on the edge that takes the strobe
    task automatic rd(logic [15:0] a, output logic [7:0] d);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
        @(negedge clk);
    endtask : rd
    task automatic wait_rel();
        int n = 0;
        while (rel !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            err_total++;
            $display("[ERR] release exp 1 got 0");
            conclude();
        end else begin
            chk("late_capture", 8'h01, {7'h0, n > 20});
        end
    endtask : wait_rel
    function automatic logic [7:0] ex(logic [STRAP_W-1:0] p, logic [7:0] i);
        logic [STRAP_W-1:0] b;
        b = (p & ~RSV_MSK) | RSV_UP;
        case (i)
            IDX_CAPTURE_0: ex = {b[7:6], b[9:8], 1'b0, b[5:4], b[17]};
            IDX_CAPTURE_1: ex = {b[40], b[14:10], 1'b0, b[36]};
            IDX_CLK_PAD: ex = {3'h0, b[20:18], 2'h0};
            IDX_HCLK_SPEED: ex = {b[3:2], b[26:23], 1'b0, b[21]};
            default: ex = 8'h00;
        endcase
    endfunction : ex
    // internal-only straps sit at their board pull levels
    function automatic logic [13:0] hid(logic [STRAP_W-1:0] p);
        logic [STRAP_W-1:0] b;
        b = (p & ~RSV_MSK) | RSV_UP;
        hid = {b[38], b[37], b[35:27], b[16], b[15], b[1]};
    endfunction : hid
    initial begin
        {rst_n, io_wr, io_rd, io_addr, io_wdata, user} = '0;
        for (int r = 0; r < 4; r++) begin
            user = ROWS[r].pins;
            rst_n = 1'b0;
            repeat (20) @(negedge clk);
            rst_n = 1'b1;
            wr(INDEX_PORT, IDX_CAPTURE_0);
            rd(DATA_PORT, v);
            chk("early", 8'h00, v);
            wait_rel();
            foreach (IDXS[k]) begin
                wr(INDEX_PORT, IDXS[k]);
                rd(DATA_PORT, v);
                ev = ex(user, IDXS[k]);
                case (k)
                    0: chk("reg_4a", ev, v);
                    1: chk("reg_4b", ev, v);
                    2: chk("reg_4c", ev, v);
                    default: chk("reg_5f", ev, v);
                endcase
            end
            ev = {3'h0, ROWS[r].en, ROWS[r].fl};
            chk("bus", ev, {3'h0, bus_en, hi, rsv});
            hx = hid(user);
            chk("hid_lo", hx[7:0], cfg.hidden[7:0]);
            chk("hid_hi", 8'(hx[13:8]), 8'(cfg.hidden[13:8]));
            user = ~user;
            repeat (8) @(negedge clk);
            wr(INDEX_PORT, IDX_CAPTURE_1);
            rd(DATA_PORT, v);
            chk("kept", ex(ROWS[r].pins, IDX_CAPTURE_1), v);
        end
        foreach (IDXS[k]) begin
            wr(INDEX_PORT, IDXS[k]);
            wr(DATA_PORT, 8'hff);
            rd(DATA_PORT, v);
            chk("write", ex(ROWS[3].pins, IDXS[k]) | WMSK[k], v);
        end
        wr(INDEX_PORT, 8'h4d);
        rd(DATA_PORT, v);
        chk("unknown", 8'h00, v);
        rd(INDEX_PORT, v);
        chk("index", 8'h4d, v);
        rd(16'h0024, v);
        chk("unmapped", 8'h00, v);
        conclude();
    end
endmodule : boot_strap_sampler_test
`default_nettype wire
